// >>> clock_gate_pkg.sv
/*
 * Constants shared by the deep-sleep unit clock gating block: register
 * offsets, field positions, reset values, bus response codes.
 * Assumes a single system clock domain and a 32-bit AXI4-Lite register bus.
 */
package clock_gate_pkg;

	// ==========================================================
	// address map
	localparam logic [31:0] SYSCTL_BASE            = 32'h400FE000;
	localparam int          WINDOW_BITS            = 12;
	localparam logic [11:0] OFF_RUN_CLOCK_CONFIG   = 12'h060;
	localparam logic [11:0] OFF_RUN_GATE_1         = 12'h104;
	localparam logic [11:0] OFF_SLEEP_GATE_1       = 12'h114;
	localparam logic [11:0] OFF_DEEP_GATE_1        = 12'h124;

	// ==========================================================
	// gating field positions
	localparam int POS_COMPARATOR_B   = 25;
	localparam int POS_COMPARATOR_A   = 24;
	localparam int POS_GP_COUNT_D     = 19;
	localparam int POS_GP_COUNT_C     = 18;
	localparam int POS_GP_COUNT_B     = 17;
	localparam int POS_GP_COUNT_A     = 16;
	localparam int POS_TWO_WIRE_B     = 14;
	localparam int POS_TWO_WIRE_A     = 12;
	localparam int POS_SYNC_SERIAL_B  = 5;
	localparam int POS_SYNC_SERIAL_A  = 4;
	localparam int POS_ASYNC_SERIAL_C = 2;
	localparam int POS_ASYNC_SERIAL_B = 1;
	localparam int POS_ASYNC_SERIAL_A = 0;

	// implemented gating bits; every other position is reserved
	localparam logic [31:0] GATE_1_MASK  = 32'h030F5037;
	localparam logic [31:0] GATE_1_RESET = 32'h00000000;

	// ==========================================================
	// run clock configuration
	localparam int          POS_AUTO_GATING_SELECT = 0;
	localparam logic [31:0] RUN_CLOCK_CONFIG_MASK  = 32'h00000001;
	localparam logic [31:0] RUN_CLOCK_CONFIG_RESET = 32'h00000000;

	// ==========================================================
	// bus responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_DECERR = 2'h3;

endpackage : clock_gate_pkg

// >>> unit_clock_gate.sv
/*
 * Glitch-free clock gate for one peripheral unit clock.
 * Assumes the enable changes only just after a rising edge of aclk; it is
 * captured on the falling edge so the gated clock never shows a runt pulse.
 */
`timescale 1ns/10ps
module unit_clock_gate (
	// clock and reset
	input  wire logic aclk,
	input  wire logic aresetn,
	// control
	input  wire logic enable,
	// gated clock
	output logic      gated_clk
);

	typedef struct packed {
		logic en_low;
	} gate_state_t;

	gate_state_t state;
	gate_state_t next_state;

	// ==========================================================
	// enable capture while the clock is low
	always_comb begin
		next_state        = state;
		next_state.en_low = enable;
		if (!aresetn) begin
			next_state.en_low = 1'b0;
		end
	end

	// the enable only moves while aclk is low, so the and gate cannot glitch
	always_ff @(negedge aclk) begin
		state <= next_state;
	end

	assign gated_clk = aclk & state.en_low;

endmodule : unit_clock_gate

// >>> deep_sleep_clock_gating.sv
/*
 * Unit clock gating control: run, sleep and deep-sleep gating registers,
 * run clock configuration with the auto-gating select, an AXI4-Lite slave
 * for them, the gated unit clocks and a bus fault check for unit accesses.
 * Assumes sleep and deep-sleep requests and unit access probes come from
 * logic on aclk, so they pass no synchroniser.
 */
// The AXI4-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/10ps
module deep_sleep_clock_gating
	import clock_gate_pkg::*;
#(
	parameter logic [31:0] BASE_ADDR = SYSCTL_BASE
) (
	// clock and reset
	input  wire logic        aclk,
	input  wire logic        aresetn,
	// axi4-lite write address
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_awaddr,
	input  wire logic [2:0]  s_axi_awprot,
	// axi4-lite write data
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	// axi4-lite write response
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	output logic [1:0]       s_axi_bresp,
	// axi4-lite read address
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	input  wire logic [31:0] s_axi_araddr,
	input  wire logic [2:0]  s_axi_arprot,
	// axi4-lite read data
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	// power state from the power controller
	input  wire logic        sleep_request,
	input  wire logic        deep_sleep_request,
	// unit access probe from the peripheral bus
	input  wire logic        unit_access_valid,
	input  wire logic [4:0]  unit_access_select,
	output logic             unit_access_fault,
	output logic             unit_access_ok,
	// gated clocks and enables
	output logic [31:0]      unit_clock_enable,
	output logic [31:0]      unit_clk,
	output logic [2:0]       power_mode
);

	// ==========================================================
	// elaboration check
	if (BASE_ADDR[WINDOW_BITS-1:0] != '0) begin : g_base_check
		$error("base address must be aligned to the register window");
	end

	// ==========================================================
	// types
	typedef enum logic [2:0] {
		MODE_RUN   = 3'b001,
		MODE_SLEEP = 3'b010,
		MODE_DEEP  = 3'b100
	} mode_t;

	typedef struct packed {
		logic        aw_held;
		logic [11:0] aw_offset;
		logic        aw_mapped;
		logic        w_held;
		logic [31:0] w_data;
		logic [3:0]  w_strb;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
		logic [31:0] run_gate_1;
		logic [31:0] sleep_gate_1;
		logic [31:0] deep_sleep_unit_clock_gate_1;
		logic [31:0] run_clock_configuration;
		mode_t       mode;
		logic [31:0] active_gate;
		logic        fault;
		logic        ok;
	} ctrl_state_t;

	ctrl_state_t state;
	ctrl_state_t next_state;

	// ==========================================================
	// helpers
	function automatic logic in_window(input logic [31:0] addr);
		in_window = (addr[31:WINDOW_BITS] == BASE_ADDR[31:WINDOW_BITS]) &&
			(addr[1:0] == 2'h0);
	endfunction : in_window

	function automatic logic is_mapped(input logic [11:0] off);
		is_mapped = (off == OFF_RUN_CLOCK_CONFIG) || (off == OFF_RUN_GATE_1) ||
			(off == OFF_SLEEP_GATE_1) || (off == OFF_DEEP_GATE_1);
	endfunction : is_mapped

	// byte lanes merged, then reserved positions forced back to zero
	function automatic logic [31:0] merge(input logic [31:0] old_value,
		input logic [31:0] new_value, input logic [3:0] strb, input logic [31:0] mask);
		logic [31:0] result;
		result = old_value;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				result[8*i +: 8] = new_value[8*i +: 8];
			end
		end
		merge = result & mask;
	endfunction : merge

	function automatic logic [31:0] read_value(input ctrl_state_t s, input logic [11:0] off);
		logic [31:0] value;
		value = 32'h00000000;
		case (off)
			OFF_RUN_CLOCK_CONFIG: value = s.run_clock_configuration;
			OFF_RUN_GATE_1:       value = s.run_gate_1;
			OFF_SLEEP_GATE_1:     value = s.sleep_gate_1;
			OFF_DEEP_GATE_1:      value = s.deep_sleep_unit_clock_gate_1;
			default:              value = 32'h00000000;
		endcase
		read_value = value;
	endfunction : read_value

	// ==========================================================
	// bus handshakes
	logic        aw_take;
	logic        w_take;
	logic        ar_take;
	logic        aw_have;
	logic        w_have;
	logic [11:0] wr_offset;
	logic        wr_mapped;
	logic [31:0] wr_data;
	logic [3:0]  wr_strb;
	logic        auto_gating_select;

	// address and data are taken in either order; a new pair waits for bready
	assign s_axi_awready = !state.aw_held && !state.bvalid;
	assign s_axi_wready  = !state.w_held && !state.bvalid;
	assign s_axi_arready = !state.rvalid;

	assign aw_take   = s_axi_awvalid && s_axi_awready;
	assign w_take    = s_axi_wvalid && s_axi_wready;
	assign ar_take   = s_axi_arvalid && s_axi_arready;
	assign aw_have   = state.aw_held || aw_take;
	assign w_have    = state.w_held || w_take;
	assign wr_offset = state.aw_held ? state.aw_offset : s_axi_awaddr[11:0];
	assign wr_mapped = state.aw_held ? state.aw_mapped :
		(in_window(s_axi_awaddr) && is_mapped(s_axi_awaddr[11:0]));
	assign wr_data   = state.w_held ? state.w_data : s_axi_wdata;
	assign wr_strb   = state.w_held ? state.w_strb : s_axi_wstrb;

	assign auto_gating_select = state.run_clock_configuration[POS_AUTO_GATING_SELECT];

	// ==========================================================
	// next state
	always_comb begin
		next_state = state;

		// write channel
		if (aw_take) begin
			next_state.aw_held   = 1'b1;
			next_state.aw_offset = s_axi_awaddr[11:0];
			next_state.aw_mapped = in_window(s_axi_awaddr) && is_mapped(s_axi_awaddr[11:0]);
		end
		if (w_take) begin
			next_state.w_held = 1'b1;
			next_state.w_data = s_axi_wdata;
			next_state.w_strb = s_axi_wstrb;
		end
		if (state.bvalid && s_axi_bready) begin
			next_state.bvalid = 1'b0;
		end
		if (aw_have && w_have && !state.bvalid) begin
			next_state.aw_held = 1'b0;
			next_state.w_held  = 1'b0;
			next_state.bvalid  = 1'b1;
			next_state.bresp   = wr_mapped ? RESP_OKAY : RESP_DECERR;
			if (wr_mapped) begin
				case (wr_offset)
					OFF_RUN_CLOCK_CONFIG: next_state.run_clock_configuration =
						merge(state.run_clock_configuration, wr_data, wr_strb,
						RUN_CLOCK_CONFIG_MASK);
					OFF_RUN_GATE_1: next_state.run_gate_1 =
						merge(state.run_gate_1, wr_data, wr_strb, GATE_1_MASK);
					OFF_SLEEP_GATE_1: next_state.sleep_gate_1 =
						merge(state.sleep_gate_1, wr_data, wr_strb, GATE_1_MASK);
					// all unit positions are plain read-write bits of the mask
					OFF_DEEP_GATE_1: next_state.deep_sleep_unit_clock_gate_1 =
						merge(state.deep_sleep_unit_clock_gate_1, wr_data, wr_strb,
						GATE_1_MASK);
					default: next_state.bresp = RESP_DECERR;
				endcase
			end
		end

		// read channel
		if (state.rvalid && s_axi_rready) begin
			next_state.rvalid = 1'b0;
		end
		if (ar_take) begin
			next_state.rvalid = 1'b1;
			if (in_window(s_axi_araddr) && is_mapped(s_axi_araddr[11:0])) begin
				next_state.rdata = read_value(state, s_axi_araddr[11:0]);
				next_state.rresp = RESP_OKAY;
			end else begin
				next_state.rdata = 32'h00000000;
				next_state.rresp = RESP_DECERR;
			end
		end

		// power mode; deep-sleep wins over sleep
		if (auto_gating_select && deep_sleep_request) begin
			next_state.mode = MODE_DEEP;
		end else if (auto_gating_select && sleep_request) begin
			next_state.mode = MODE_SLEEP;
		end else begin
			next_state.mode = MODE_RUN;
		end

		// the enables follow the register of the current mode only
		case (state.mode)
			MODE_RUN:   next_state.active_gate = state.run_gate_1;
			MODE_SLEEP: next_state.active_gate = state.sleep_gate_1;
			MODE_DEEP:  next_state.active_gate = state.deep_sleep_unit_clock_gate_1;
			default:    next_state.active_gate = state.run_gate_1;
		endcase

		// unit access check, answered one cycle after the probe
		next_state.fault = unit_access_valid && !state.active_gate[unit_access_select];
		next_state.ok    = unit_access_valid && state.active_gate[unit_access_select];

		// all registers zero except mode, which loads MODE_RUN; every unit starts unclocked
		if (!aresetn) begin
			next_state.aw_held                      = 1'b0;
			next_state.aw_offset                    = 12'h000;
			next_state.aw_mapped                    = 1'b0;
			next_state.w_held                       = 1'b0;
			next_state.w_data                       = 32'h00000000;
			next_state.w_strb                       = 4'h0;
			next_state.bvalid                       = 1'b0;
			next_state.bresp                        = RESP_OKAY;
			next_state.rvalid                       = 1'b0;
			next_state.rdata                        = 32'h00000000;
			next_state.rresp                        = RESP_OKAY;
			next_state.run_gate_1                   = GATE_1_RESET;
			next_state.sleep_gate_1                 = GATE_1_RESET;
			next_state.deep_sleep_unit_clock_gate_1 = GATE_1_RESET;
			next_state.run_clock_configuration      = RUN_CLOCK_CONFIG_RESET;
			next_state.mode                         = MODE_RUN;
			next_state.active_gate                  = GATE_1_RESET;
			next_state.fault                        = 1'b0;
			next_state.ok                           = 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		state <= next_state;
	end

	// ==========================================================
	// outputs
	assign s_axi_bvalid      = state.bvalid;
	assign s_axi_bresp       = state.bresp;
	assign s_axi_rvalid      = state.rvalid;
	assign s_axi_rdata       = state.rdata;
	assign s_axi_rresp       = state.rresp;
	assign unit_access_fault = state.fault;
	assign unit_access_ok    = state.ok;
	assign unit_clock_enable = state.active_gate;
	assign power_mode        = state.mode;

	// ==========================================================
	// gated unit clocks; reserved positions have a gate whose enable stays low
	for (genvar g = 0; g < 32; g++) begin : g_gate
		unit_clock_gate u_gate (
			.aclk      (aclk),
			.aresetn   (aresetn),
			.enable    (state.active_gate[g]),
			.gated_clk (unit_clk[g])
		);
	end

endmodule : deep_sleep_clock_gating

// >>> gate_checker.sv
/*
 * Concurrent checks on the unit clock gating block's ports.
 * Assumes a bind from the bench top and one clock domain on aclk.
 */
`timescale 1ns/10ps
module gate_checker
	import clock_gate_pkg::*;
(
	// clock and reset
	input wire logic        aclk,
	input wire logic        aresetn,
	// register bus
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic [1:0]  s_axi_bresp,
	// unit probe and clocks
	input wire logic        unit_access_valid,
	input wire logic [4:0]  unit_access_select,
	input wire logic        unit_access_fault,
	input wire logic        unit_access_ok,
	input wire logic [31:0] unit_clock_enable,
	input wire logic [31:0] unit_clk,
	input wire logic [2:0]  power_mode
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	// ==========================================================
	// sequences
	sequence s_probe_off;
		unit_access_valid && !unit_clock_enable[unit_access_select];
	endsequence
	sequence s_probe_on;
		unit_access_valid && unit_clock_enable[unit_access_select];
	endsequence
	sequence s_read_taken;
		s_axi_arvalid && s_axi_arready;
	endsequence

	// ==========================================================
	// properties
	chk_reset_clear: assert property ($rose(aresetn) |-> unit_clock_enable == 32'h0)
		else $error("enables not clear after reset");
	chk_reserved_off: assert property (((unit_clock_enable | unit_clk) & ~GATE_1_MASK) == 32'h0)
		else $error("reserved position enabled");
	chk_fault_off: assert property (s_probe_off |=> unit_access_fault && !unit_access_ok)
		else $error("no fault for gated unit");
	chk_ok_on: assert property (s_probe_on |=> unit_access_ok && !unit_access_fault)
		else $error("clocked unit refused");
	chk_probe_quiet: assert property (!unit_access_valid |=> !unit_access_fault && !unit_access_ok)
		else $error("probe result without probe");
	chk_read_answer: assert property (s_read_taken |=> s_axi_rvalid)
		else $error("read answer late");
	chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	chk_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped");
	chk_mode_onehot: assert property ($onehot(power_mode))
		else $error("power mode not one-hot");
endmodule : gate_checker

// >>> tb.sv
/*
 * Self-checking bench for the unit clock gating block.
 * Assumes the package constants and the default base address.
 */
`timescale 1ns/10ps
module tb
	import clock_gate_pkg::*;
;
	localparam logic [31:0] A_DEEP = SYSCTL_BASE + 32'(OFF_DEEP_GATE_1);
	localparam logic [31:0] A_RUN  = SYSCTL_BASE + 32'(OFF_RUN_GATE_1);
	localparam logic [31:0] A_SLP  = SYSCTL_BASE + 32'(OFF_SLEEP_GATE_1);
	localparam logic [31:0] A_RCC  = SYSCTL_BASE + 32'(OFF_RUN_CLOCK_CONFIG);
	logic        aclk = 1'b0;
	logic        aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
	logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, unit_clock_enable, unit_clk;
	logic        sleep_request, deep_sleep_request, unit_access_valid, unit_access_fault;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, unit_access_ok;
	logic [4:0]  unit_access_select;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic [2:0]  power_mode;
	logic [31:0] exp_rd[$], run_v, sleep_v, deep_v, d;
	logic [1:0]  exp_rr[$], exp_b[$], exp_pr[$];
	int          fails, checks_done;

	deep_sleep_clock_gating deep_sleep_clock_gating_i (
		.aclk               (aclk),
		.aresetn            (aresetn),
		.s_axi_awvalid      (s_axi_awvalid),
		.s_axi_awready      (s_axi_awready),
		.s_axi_awaddr       (s_axi_awaddr),
		.s_axi_awprot       (3'h0),
		.s_axi_wvalid       (s_axi_wvalid),
		.s_axi_wready       (s_axi_wready),
		.s_axi_wdata        (s_axi_wdata),
		.s_axi_wstrb        (4'hF),
		.s_axi_bvalid       (s_axi_bvalid),
		.s_axi_bready       (s_axi_bready),
		.s_axi_bresp        (s_axi_bresp),
		.s_axi_arvalid      (s_axi_arvalid),
		.s_axi_arready      (s_axi_arready),
		.s_axi_araddr       (s_axi_araddr),
		.s_axi_arprot       (3'h0),
		.s_axi_rvalid       (s_axi_rvalid),
		.s_axi_rready       (s_axi_rready),
		.s_axi_rdata        (s_axi_rdata),
		.s_axi_rresp        (s_axi_rresp),
		.sleep_request      (sleep_request),
		.deep_sleep_request (deep_sleep_request),
		.unit_access_valid  (unit_access_valid),
		.unit_access_select (unit_access_select),
		.unit_access_fault  (unit_access_fault),
		.unit_access_ok     (unit_access_ok),
		.unit_clock_enable  (unit_clock_enable),
		.unit_clk           (unit_clk),
		.power_mode         (power_mode)
	);

	always #2 aclk = ~aclk;

	// ==========================================================
	// compares and bus tasks
	task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			fails++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : cmp_word

	task automatic cmp_code(input logic [1:0] got, input logic [1:0] exp);
		checks_done++;
		if (got !== exp) begin
			fails++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : cmp_code

	task automatic wr(input logic [31:0] a, input logic [31:0] v, input logic [1:0] r);
		bit ad = 0;
		bit wd = 0;
		exp_b.push_back(r);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		while (!(ad && wd)) begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready) begin
				ad = 1;
				s_axi_awvalid <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wd = 1;
				s_axi_wvalid <= 1'b0;
			end
		end
		// a late bready lets the response stand for a few cycles
		repeat ($urandom_range(2)) @(posedge aclk);
		s_axi_bready <= 1'b1;
		do @(posedge aclk); while (!s_axi_bvalid);
		s_axi_bready <= 1'b0;
	endtask : wr

	task automatic rd(input logic [31:0] a, input logic [31:0] v, input logic [1:0] r);
		exp_rd.push_back(v);
		exp_rr.push_back(r);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do @(posedge aclk); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		// rready rises only after the address is taken and drops once rvalid is seen, so back-to-back reads toggle it each time
		repeat ($urandom_range(2)) @(posedge aclk);
		s_axi_rready <= 1'b1;
		do @(posedge aclk); while (!s_axi_rvalid);
		s_axi_rready <= 1'b0;
	endtask : rd

	// expected code is {fault, ok}
	task automatic probe(input logic [4:0] s, input logic [1:0] e);
		exp_pr.push_back(e);
		unit_access_valid <= 1'b1;
		unit_access_select <= s;
		@(posedge aclk);
		unit_access_valid <= 1'b0;
		@(posedge aclk);
	endtask : probe

	task automatic end_sim;
		// notes that never met a result count as mismatches
		fails += exp_rd.size() + exp_rr.size() + exp_b.size() + exp_pr.size();
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : end_sim

	// ==========================================================
	// result monitor: oldest note against each result seen
	always @(posedge aclk) begin
		if (aresetn && s_axi_rvalid && s_axi_rready) begin
			cmp_word(s_axi_rdata, exp_rd.pop_front());
			cmp_code(s_axi_rresp, exp_rr.pop_front());
		end
		if (aresetn && s_axi_bvalid && s_axi_bready)
			cmp_code(s_axi_bresp, exp_b.pop_front());
		if (unit_access_fault || unit_access_ok)
			cmp_code({unit_access_fault, unit_access_ok}, exp_pr.pop_front());
	end

	// a hang costs a mismatch; the whole run needs well under 2000 cycles
	initial begin
		repeat (20000) @(posedge aclk);
		fails++;
		end_sim();
	end

	// ==========================================================
	// scenarios
	initial begin
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
		{sleep_request, deep_sleep_request, unit_access_valid, unit_access_select} = '0;
		void'($urandom(79789));
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rd(A_DEEP, 32'h0, RESP_OKAY);
		rd(A_RUN, 32'h0, RESP_OKAY);
		for (int i = 0; i < 32; i++) begin
			wr(A_DEEP, 32'h1 << i, RESP_OKAY);
			rd(A_DEEP, (32'h1 << i) & GATE_1_MASK, RESP_OKAY);
		end
		d = $urandom;
		wr(A_DEEP, d, RESP_OKAY);
		wr(A_DEEP + 32'h2, ~d, RESP_DECERR);
		wr(SYSCTL_BASE + 32'h200, ~d, RESP_DECERR);
		rd(SYSCTL_BASE + 32'h200, 32'h0, RESP_DECERR);
		rd(A_DEEP, d & GATE_1_MASK, RESP_OKAY);
		run_v = $urandom & GATE_1_MASK;
		sleep_v = $urandom & GATE_1_MASK;
		deep_v = $urandom & GATE_1_MASK;
		wr(A_RUN, run_v, RESP_OKAY);
		wr(A_SLP, sleep_v, RESP_OKAY);
		wr(A_DEEP, deep_v, RESP_OKAY);
		// without the auto-gating select the run word stays in charge
		deep_sleep_request <= 1'b1;
		repeat (3) @(posedge aclk);
		cmp_word(unit_clock_enable, run_v);
		cmp_word(32'(power_mode), 32'h00000001);
		wr(A_RCC, 32'h1, RESP_OKAY);
		repeat (3) @(posedge aclk);
		cmp_word(unit_clock_enable, deep_v);
		cmp_word(32'(power_mode), 32'h00000004);
		for (int i = 0; i < 32; i++)
			probe(5'(i), deep_v[i] ? 2'b01 : 2'b10);
		#1;
		cmp_word(unit_clk, deep_v);
		// back onto the rising edge before the next input change
		@(posedge aclk);
		deep_sleep_request <= 1'b0;
		sleep_request <= 1'b1;
		repeat (3) @(posedge aclk);
		cmp_word(unit_clock_enable, sleep_v);
		cmp_word(32'(power_mode), 32'h00000002);
		// software flips one unit bit and writes back whatever it read
		rd(A_DEEP, deep_v, RESP_OKAY);
		wr(A_DEEP, deep_v ^ (32'h1 << POS_TWO_WIRE_A), RESP_OKAY);
		rd(A_DEEP, deep_v ^ (32'h1 << POS_TWO_WIRE_A), RESP_OKAY);
		cmp_word(unit_clock_enable, sleep_v);
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rd(A_DEEP, 32'h0, RESP_OKAY);
		cmp_word(unit_clock_enable, 32'h0);
		cmp_word(32'(power_mode), 32'h00000001);
		// let the monitor take the last answer before the verdict
		@(posedge aclk);
		end_sim();
	end
endmodule : tb

bind deep_sleep_clock_gating gate_checker gate_checker_i (
	.aclk               (aclk),
	.aresetn            (aresetn),
	.s_axi_arvalid      (s_axi_arvalid),
	.s_axi_arready      (s_axi_arready),
	.s_axi_rvalid       (s_axi_rvalid),
	.s_axi_rready       (s_axi_rready),
	.s_axi_rdata        (s_axi_rdata),
	.s_axi_bvalid       (s_axi_bvalid),
	.s_axi_bready       (s_axi_bready),
	.s_axi_bresp        (s_axi_bresp),
	.unit_access_valid  (unit_access_valid),
	.unit_access_select (unit_access_select),
	.unit_access_fault  (unit_access_fault),
	.unit_access_ok     (unit_access_ok),
	.unit_clock_enable  (unit_clock_enable),
	.unit_clk           (unit_clk),
	.power_mode         (power_mode)
);
